// ==== rtl/flash_prot_pkg.sv ====
// Package with function register layout, protection codes and block geometry.
package flash_prot_pkg;
    localparam int BLOCK_COUNT = 64;
    localparam int BLOCK_BITS = 6;
    localparam int FUNC_WIDTH = 8;
    localparam int CODE_WIDTH = 4;
    localparam int ROW_COUNT = 4;
    // Function register field positions.
    localparam int RESET_DISABLE_POS = 0;
    localparam int TOP_BOTTOM_POS = 1;
    localparam int PROGRAM_SUSP_POS = 2;
    localparam int ERASE_SUSP_POS = 3;
    localparam int ROW_LOCK_POS = 4;
    // Reset values of the fields that do not depend on the variant.
    localparam logic TOP_BOTTOM_RESET = 1'h0;
    localparam logic [3:0] ROW_LOCK_RESET = 4'h0;
    // Protection codes with special meaning.
    localparam logic [3:0] CODE_NONE_LOW = 4'h0;
    localparam logic [3:0] CODE_ALL_A = 4'h7;
    localparam logic [3:0] CODE_ALL_B = 4'h8;
    localparam logic [3:0] CODE_NONE_HIGH = 4'hF;
    localparam logic [3:0] CODE_LOW_FIRST = 4'h9;
    // Operation kinds presented for a protection check.
    typedef enum logic [1:0] {OP_PROGRAM, OP_ERASE, OP_WHOLE_ERASE, OP_ROW_PROGRAM} op_kind_t;
    // Suspend tracker states.
    typedef enum logic [1:0] {SUSP_IDLE, SUSP_PROGRAM, SUSP_ERASE} susp_state_t;
endpackage : flash_prot_pkg

// ==== rtl/prot_range_if.sv ====
// Interface carrying a protection code and its decoded block range.
interface prot_range_if;
    logic [3:0] code;
    logic bottomSel;
    logic [5:0] firstBlock;
    logic [5:0] lastBlock;
    logic anyProtected;
    modport decoder (input code, input bottomSel, output firstBlock, output lastBlock, output anyProtected);
    modport user (output code, output bottomSel, input firstBlock, input lastBlock, input anyProtected);
endinterface : prot_range_if

// ==== rtl/prot_range_decode.sv ====
// Decoder from a block-protection code to a contiguous range of protected blocks.
module prot_range_decode #(
    parameter bit TOP_BOTTOM_USED = 1'b1
) (
    prot_range_if.decoder rng
);
    ////////////////////////////////////////////////////////////////////////////////
    // Span size as a power of two from the code's low bits.
    function automatic logic [6:0] span_of(input logic [3:0] code);
        logic [6:0] span;
        span = 7'h00;
        if (code >= 4'h1 && code <= 4'h6) begin
            span = 7'(7'h01 << (code - 4'h1)); // [R2]
        end else if (code >= flash_prot_pkg::CODE_LOW_FIRST && code <= 4'hE) begin
            span = 7'(7'h20 >> (code - flash_prot_pkg::CODE_LOW_FIRST)); // [R3]
        end else if (code == flash_prot_pkg::CODE_ALL_A || code == flash_prot_pkg::CODE_ALL_B) begin
            span = 7'h40; // [R4]
        end
        return span;
    endfunction : span_of

    logic [6:0] span;
    logic lowSide;

    // Codes 9..14 are bottom ranges; the select bit swaps top and bottom ranges. [R1]
    always_comb begin
        span = span_of(rng.code);
        lowSide = (rng.code >= flash_prot_pkg::CODE_LOW_FIRST) ^ (TOP_BOTTOM_USED && rng.bottomSel); // [R10]
        rng.anyProtected = (span != 7'h00); // [R4]
        if (span == 7'h40) begin
            rng.firstBlock = 6'h00;
            rng.lastBlock = 6'h3F;
        end else if (lowSide) begin
            rng.firstBlock = 6'h00; // [R3]
            rng.lastBlock = 6'(span - 7'h01);
        end else begin
            rng.firstBlock = 6'(7'h40 - span); // [R2]
            rng.lastBlock = 6'h3F;
        end
    end
endmodule : prot_range_decode

// ==== rtl/flash_function_reg_protect.sv ====
// Function register, suspend flags and block-protection checking of a serial flash.
// Function
// R1: The four-bit protection code selects protected 64 KB blocks out of 64.
// R2: Codes 1 to 6 protect top 1,2,4,8,16,32 blocks ending at block 63.
// R3: Codes 9 to 14 protect bottom 32,16,8,4,2,1 blocks starting at block 0.
// R4: Codes 0 and 15 protect nothing; codes 7 and 8 protect everything.
// R5: Eight-bit function register: reset disable, top/bottom, suspends, four row locks.
// R6: One-time bits stay one forever once written one; zero writes ignored. Here nrst restores their reset values.
// R7: Reset-disable bit resets per variant and is writable only while zero.
// R8: When reset-disable is one, hardware reset moves to the hold/reset pin.
// R9: Top/bottom bit resets to top; one selects bottom, irreversibly.
// R10: In the 32 Mbit density the top/bottom bit is reserved, no effect.
// R11: Program-suspended flag sets on suspend during program, clears on resume.
// R12: Erase-suspended flag sets on suspend during erase, clears on resume.
// R13: Suspend flags are volatile, read-only, zero when nothing is suspended.
// R14: Row lock n resets to zero; once one, programming row n is refused.
// R15: Host writes to the function register leave the suspend flags unchanged.
// R16: Program or erase whose target lies in the protected area is rejected.
// R17: Whole-array erase is ignored unless all four protection bits are zero.
module flash_function_reg_protect #(
    parameter bit RESET_DISABLE_DEFAULT = 1'b0,
    parameter bit DENSITY_32MBIT = 1'b1
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic nrst,
    // Status register protection bits.
    input wire logic protect_code_bit3,
    input wire logic protect_code_bit2,
    input wire logic protect_code_bit1,
    input wire logic protect_code_bit0,
    // Function register write and read.
    input wire logic funcWrite,
    input wire logic [7:0] funcWriteData,
    output logic [7:0] funcReadData,
    // Suspend and resume events from the command sequencer.
    input wire logic suspendAccepted,
    input wire logic programActive,
    input wire logic eraseActive,
    input wire logic resumeAccepted,
    // Operation check request.
    input wire logic checkValid,
    input wire flash_prot_pkg::op_kind_t checkKind,
    input wire logic [5:0] checkFirstBlock,
    input wire logic [5:0] checkLastBlock,
    input wire logic [1:0] checkRow,
    output logic checkAllowed,
    output logic checkRejected,
    // Reset pin routing.
    input wire logic dedicatedResetPin,
    input wire logic holdResetPin,
    output logic hwResetRequest,
    output logic holdPinIsReset,
    // Decoded protection range.
    output logic [5:0] protFirstBlock,
    output logic [5:0] protLastBlock,
    output logic protAny
);
    ////////////////////////////////////////////////////////////////////////////////
    // One-time bits and suspend state.
    logic resetDisable;
    logic topBottom;
    logic [3:0] rowLock;
    logic next_resetDisable;
    logic next_topBottom;
    logic [3:0] next_rowLock;
    // Suspend tracker state.
    flash_prot_pkg::susp_state_t suspState;
    flash_prot_pkg::susp_state_t next_suspState;
    // Code, flags and the registered check answer.
    logic [3:0] protCode;
    logic program_suspended_flag;
    logic erase_suspended_flag;
    logic inRange;
    logic next_checkAllowed;
    logic next_checkRejected;
    logic [7:0] next_funcReadData;

    // Link between this register block and the code decoder.
    prot_range_if rng ();

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks: the decoder and the register image serve one fixed geometry.
    if ($bits(protCode) != flash_prot_pkg::CODE_WIDTH) begin : g_code_width_bad
        $error("Protection code width differs from the package.");
    end
    if ($bits(protFirstBlock) != flash_prot_pkg::BLOCK_BITS
            || flash_prot_pkg::BLOCK_COUNT != (1 << flash_prot_pkg::BLOCK_BITS)) begin : g_geometry_bad
        $error("Block count and block index width do not agree.");
    end
    if ($bits(funcReadData) != flash_prot_pkg::FUNC_WIDTH
            || $bits(rowLock) != flash_prot_pkg::ROW_COUNT) begin : g_layout_bad
        $error("Function register layout differs from the package.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The four pins form one code with bit 3 on top; the decoder turns it into a range.
    assign protCode = {protect_code_bit3, protect_code_bit2, protect_code_bit1, protect_code_bit0}; // [R1]
    assign rng.code = protCode;
    assign rng.bottomSel = topBottom;

    prot_range_decode #(.TOP_BOTTOM_USED(!DENSITY_32MBIT)) u_decode (.rng(rng.decoder));

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky one-time bits: writes only ever OR ones in.
    // The reset-disable bit is gated too, so a zero written after it is set changes nothing.
    always_comb begin
        next_resetDisable = resetDisable;
        next_topBottom = topBottom;
        next_rowLock = rowLock;
        if (funcWrite) begin
            if (!resetDisable) begin
                next_resetDisable = funcWriteData[flash_prot_pkg::RESET_DISABLE_POS]; // [R7]
            end
            next_topBottom = topBottom | funcWriteData[flash_prot_pkg::TOP_BOTTOM_POS]; // [R6] [R9]
            next_rowLock = rowLock
                | funcWriteData[flash_prot_pkg::ROW_LOCK_POS +: flash_prot_pkg::ROW_COUNT]; // [R6] [R14]
        end
    end

    // Registers the one-time bits; reset restores their delivered state.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            resetDisable <= RESET_DISABLE_DEFAULT; // [R7]
            topBottom <= flash_prot_pkg::TOP_BOTTOM_RESET; // [R9]
            rowLock <= flash_prot_pkg::ROW_LOCK_RESET; // [R14]
        end else begin
            resetDisable <= next_resetDisable;
            topBottom <= next_topBottom;
            rowLock <= next_rowLock;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Suspend tracker; host writes never touch it.
    // Program wins when both operations report active; a suspend while suspended is ignored.
    always_comb begin
        next_suspState = suspState;
        case (suspState)
            flash_prot_pkg::SUSP_IDLE: begin
                if (suspendAccepted && programActive) begin
                    next_suspState = flash_prot_pkg::SUSP_PROGRAM; // [R11]
                end else if (suspendAccepted && eraseActive) begin
                    next_suspState = flash_prot_pkg::SUSP_ERASE; // [R12]
                end
            end
            flash_prot_pkg::SUSP_PROGRAM, flash_prot_pkg::SUSP_ERASE: begin
                if (resumeAccepted) begin
                    next_suspState = flash_prot_pkg::SUSP_IDLE; // [R11] [R12]
                end
            end
            default: begin
                next_suspState = flash_prot_pkg::SUSP_IDLE;
            end
        endcase
    end

    // Registers the suspend state; reset leaves nothing suspended.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            suspState <= flash_prot_pkg::SUSP_IDLE; // [R13]
        end else begin
            suspState <= next_suspState;
        end
    end

    assign program_suspended_flag = (suspState == flash_prot_pkg::SUSP_PROGRAM); // [R13]
    assign erase_suspended_flag = (suspState == flash_prot_pkg::SUSP_ERASE); // [R13]

    ////////////////////////////////////////////////////////////////////////////////
    // True when the target range shares at least one block with the protected range.
    function automatic logic range_overlaps(input logic [5:0] tgtLo, input logic [5:0] tgtHi,
                                            input logic [5:0] protLo, input logic [5:0] protHi);
        return !(tgtHi < protLo || tgtLo > protHi);
    endfunction : range_overlaps

    // Protection check of a requested operation, answered one cycle later.
    // The verdict is registered so the sequencer always sees a clean one-cycle answer.
    always_comb begin
        inRange = rng.anyProtected
            && range_overlaps(checkFirstBlock, checkLastBlock, rng.firstBlock, rng.lastBlock); // [R16]
        next_checkAllowed = 1'b0;
        next_checkRejected = 1'b0;
        if (checkValid) begin
            case (checkKind)
                flash_prot_pkg::OP_WHOLE_ERASE: begin
                    next_checkRejected = (protCode != flash_prot_pkg::CODE_NONE_LOW); // [R17]
                end
                flash_prot_pkg::OP_ROW_PROGRAM: next_checkRejected = rowLock[checkRow]; // [R14]
                default: next_checkRejected = inRange; // [R16]
            endcase
            next_checkAllowed = !next_checkRejected;
        end
        // Read value assembled field by field; suspend bits come from the tracker. [R5] [R15]
        next_funcReadData = 8'h00;
        next_funcReadData[flash_prot_pkg::RESET_DISABLE_POS] = resetDisable; // [R7]
        next_funcReadData[flash_prot_pkg::TOP_BOTTOM_POS] = topBottom; // [R9]
        next_funcReadData[flash_prot_pkg::PROGRAM_SUSP_POS] = program_suspended_flag; // [R11]
        next_funcReadData[flash_prot_pkg::ERASE_SUSP_POS] = erase_suspended_flag; // [R12]
        next_funcReadData[flash_prot_pkg::ROW_LOCK_POS +: flash_prot_pkg::ROW_COUNT] = rowLock; // [R14]
    end

    // Registers the check answer and the read image.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            checkAllowed <= 1'b0;
            checkRejected <= 1'b0;
            funcReadData <= 8'h00;
        end else begin
            checkAllowed <= next_checkAllowed;
            checkRejected <= next_checkRejected;
            funcReadData <= next_funcReadData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset pin routing: the active-low reset comes from the dedicated pin or the hold pin.
    // Once routing moves, a dedicated pin left low can no longer hold the device in reset.
    assign holdPinIsReset = resetDisable; // [R8]
    assign hwResetRequest = resetDisable ? !holdResetPin : !dedicatedResetPin; // [R8]

    // Decoded range, presented for status reads and for the operation sequencer.
    assign protFirstBlock = rng.firstBlock;
    assign protLastBlock = rng.lastBlock;
    assign protAny = rng.anyProtected;
endmodule : flash_function_reg_protect

// ==== verification/flash_host_model.sv ====
// Host controller model that drives the protection code and function register writes.
module flash_host_model (
    // Clock.
    input wire logic sys_clk,
    // Driven toward the device.
    output logic [3:0] code,
    output logic funcWrite,
    output logic [7:0] funcWriteData
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle values at time zero.
    initial begin
        code = 4'h0;
        funcWrite = 1'b0;
        funcWriteData = 8'h00;
    end
    // Issues one single-cycle write strobe, changed at the falling edge.
    task automatic write_func(input logic [7:0] d);
        @(negedge sys_clk);
        funcWrite = 1'b1;
        funcWriteData = d;
        @(negedge sys_clk);
        funcWrite = 1'b0;
        funcWriteData = ~d; // Stale data is inverted so it never looks held.
    endtask : write_func
    // Loads a new protection code at the falling edge.
    task automatic set_code(input logic [3:0] c);
        @(negedge sys_clk);
        code = c;
    endtask : set_code
endmodule : flash_host_model

// ==== verification/flash_function_reg_protect_assertions.sv ====
// Checker of check answers, one-time bits, suspend flags, reset routing and range decode.
module flash_prot_checker (
    // Clock, reset and inputs.
    input wire logic sys_clk, input wire logic nrst,
    input wire logic protect_code_bit3, input wire logic protect_code_bit2,
    input wire logic protect_code_bit1, input wire logic protect_code_bit0,
    input wire logic suspendAccepted, input wire logic resumeAccepted,
    input wire logic programActive, input wire logic eraseActive,
    input wire logic checkValid, input wire flash_prot_pkg::op_kind_t checkKind,
    input wire logic dedicatedResetPin, input wire logic holdResetPin,
    // Outputs under watch.
    input wire logic [7:0] funcReadData, input wire logic checkAllowed, input wire logic checkRejected,
    input wire logic hwResetRequest, input wire logic holdPinIsReset,
    input wire logic [5:0] protLastBlock, input wire logic protAny
);
    wire [3:0] code;
    // Gathers the protection code into one value.
    assign code = {protect_code_bit3, protect_code_bit2, protect_code_bit1, protect_code_bit0};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    check_one_answer_a: assert property (checkValid |=> checkAllowed != checkRejected)
        else $error("check answer not exactly one");
    no_idle_answer_a: assert property (!checkValid |=> !checkAllowed && !checkRejected)
        else $error("check answer without request");
    whole_erase_block_a: assert property (checkValid && checkKind == flash_prot_pkg::OP_WHOLE_ERASE && code != 4'h0 |=> checkRejected)
        else $error("whole erase passed with code set");
    otp_bits_sticky_a: assert property ((funcReadData & $past(funcReadData) & 8'hF3) == ($past(funcReadData) & 8'hF3))
        else $error("one-time bit cleared");
    prog_susp_set_a: assert property (suspendAccepted && programActive && funcReadData[3:2] == 2'h0 |-> ##2 funcReadData[3:2] == 2'h1)
        else $error("program suspend flag not set");
    erase_susp_set_a: assert property (suspendAccepted && !programActive && eraseActive && funcReadData[3:2] == 2'h0 |-> ##2 funcReadData[3:2] == 2'h2)
        else $error("erase suspend flag not set");
    resume_clears_a: assert property (resumeAccepted |-> ##2 funcReadData[3:2] == 2'h0)
        else $error("suspend flag kept after resume");
    reset_route_a: assert property (hwResetRequest == (holdPinIsReset ? !holdResetPin : !dedicatedResetPin))
        else $error("reset taken from wrong pin");
    route_follows_bit_a: assert property (holdPinIsReset |=> funcReadData[0])
        else $error("pin routing disagrees with register");
    range_any_a: assert property (protAny == (code != 4'h0 && code != 4'hF))
        else $error("protected flag wrong for code");
    all_blocks_end_a: assert property ((code == 4'h7 || code == 4'h8) |-> protLastBlock == 6'h3F)
        else $error("all-block code does not reach the top block");
endmodule : flash_prot_checker
bind flash_function_reg_protect flash_prot_checker i_flash_prot_checker (.sys_clk, .nrst, .protect_code_bit3,
    .protect_code_bit2, .protect_code_bit1, .protect_code_bit0, .suspendAccepted, .resumeAccepted, .programActive,
    .eraseActive, .checkValid, .checkKind, .dedicatedResetPin, .holdResetPin, .funcReadData, .checkAllowed,
    .checkRejected, .hwResetRequest, .holdPinIsReset, .protLastBlock, .protAny);

// ==== verification/flash_function_reg_protect_test.sv ====
// Self-checking bench for the function register and protection logic.
module flash_function_reg_protect_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, nrst = 1'b0, sus = 1'b0, res = 1'b0, pAct = 1'b0, eAct = 1'b0, cv = 1'b0;
    logic dPin = 1'b1, hPin = 1'b1, fw, ok, rej, hw, hpr, pany, eA;
    flash_prot_pkg::op_kind_t kind = flash_prot_pkg::OP_ERASE;
    logic [5:0] fb = 6'h00, lb = 6'h00, pf, pl, eF, eL;
    logic [1:0] row = 2'h0;
    logic [3:0] code;
    logic [7:0] wd, rd;
    int errorCnt = 0, cmpCount = 0;
    // Free-running system clock.
    always #5 sys_clk = ~sys_clk;
    flash_host_model i_flash_host_model (.sys_clk, .code, .funcWrite(fw), .funcWriteData(wd));
    flash_function_reg_protect i_flash_function_reg_protect (.sys_clk, .nrst, .protect_code_bit3(code[3]),
        .protect_code_bit2(code[2]), .protect_code_bit1(code[1]), .protect_code_bit0(code[0]), .funcWrite(fw),
        .funcWriteData(wd), .funcReadData(rd), .suspendAccepted(sus), .programActive(pAct), .eraseActive(eAct),
        .resumeAccepted(res), .checkValid(cv), .checkKind(kind), .checkFirstBlock(fb), .checkLastBlock(lb),
        .checkRow(row), .checkAllowed(ok), .checkRejected(rej), .dedicatedResetPin(dPin), .holdResetPin(hPin),
        .hwResetRequest(hw), .holdPinIsReset(hpr), .protFirstBlock(pf), .protLastBlock(pl), .protAny(pany));
    // Counts a comparison and reports a mismatch.
    task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : cmp
    // Presents one check of blocks b to e and compares the answer one cycle later.
    task automatic chk(input flash_prot_pkg::op_kind_t k, input logic [5:0] b, input logic [5:0] e,
                       input logic [1:0] r, input logic rj);
        @(negedge sys_clk);
        cv = 1'b1;
        kind = k;
        fb = b;
        lb = e;
        row = r;
        @(negedge sys_clk);
        cv = 1'b0;
        cmp(8'({ok, rej}), 8'({~rj, rj}));
    endtask : chk
    // Pulses suspend or resume and waits until the register image shows it.
    task automatic pulse(input logic s);
        @(negedge sys_clk);
        if (s) sus = 1'b1;
        else res = 1'b1;
        @(negedge sys_clk);
        sus = 1'b0;
        res = 1'b0;
        @(negedge sys_clk);
    endtask : pulse
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // Watchdog well beyond the expected run of some one hundred fifty cycles.
    initial begin
        #100000;
        errorCnt++;
        tally_and_finish();
    end
    // Main sequence of tests.
    initial begin
        repeat (6) @(negedge sys_clk);
        nrst = 1'b1;
        @(negedge sys_clk);
        cmp(rd, 8'h00);
        $display("test reset done");
        for (int c = 0; c < 16; c++) begin
            i_flash_host_model.set_code(4'(c));
            eA = !(c == 0 || c == 15);
            eF = (c >= 1 && c <= 6) ? 6'(64 - (1 << (c - 1))) : 6'h00;
            eL = (c >= 9 && c <= 14) ? 6'((32 >> (c - 9)) - 1) : 6'h3F;
            #1;
            cmp(8'(pany), 8'(eA));
            if (eA) cmp({2'h0, pf}, {2'h0, eF});
            if (eA) cmp({2'h0, pl}, {2'h0, eL});
            chk(flash_prot_pkg::OP_ERASE, 6'h00, 6'h00, 2'h0, eA && eF == 6'h00);
            chk(flash_prot_pkg::OP_PROGRAM, 6'h3F, 6'h3F, 2'h0, eA && eL == 6'h3F);
            chk(flash_prot_pkg::OP_WHOLE_ERASE, 6'h00, 6'h00, 2'h0, c != 0);
        end
        i_flash_host_model.set_code(4'h9);
        chk(flash_prot_pkg::OP_ERASE, 6'h20, 6'h3F, 2'h0, 1'b0);
        chk(flash_prot_pkg::OP_PROGRAM, 6'h1F, 6'h20, 2'h0, 1'b1);
        $display("test decode done");
        i_flash_host_model.set_code(4'h1);
        chk(flash_prot_pkg::OP_ROW_PROGRAM, 6'h00, 6'h00, 2'h2, 1'b0);
        dPin = 1'b0;
        #1 cmp(8'(hw), 8'h01);
        i_flash_host_model.write_func(8'hFF);
        @(negedge sys_clk);
        cmp(rd, 8'hF3);
        i_flash_host_model.write_func(8'h00);
        @(negedge sys_clk);
        cmp(rd, 8'hF3);
        cmp({hpr, hw, pf}, {1'b1, 1'b0, 6'h3F});
        chk(flash_prot_pkg::OP_ROW_PROGRAM, 6'h00, 6'h00, 2'h2, 1'b1);
        $display("test function register done");
        pAct = 1'b1;
        pulse(1'b1);
        cmp(rd, 8'hF7);
        i_flash_host_model.write_func(8'h00);
        @(negedge sys_clk);
        cmp(rd, 8'hF7);
        pulse(1'b0);
        cmp(rd, 8'hF3);
        pAct = 1'b0;
        eAct = 1'b1;
        pulse(1'b1);
        cmp(rd, 8'hFB);
        pulse(1'b0);
        cmp(rd, 8'hF3);
        $display("test suspend done");
        tally_and_finish();
    end
endmodule : flash_function_reg_protect_test
